/* pmicm_defines.vh */
/*
 what the file holds: constants for the two-wire host controller
 assumes: included by the controller files, plain verilog-2005
*/
`ifndef PMICM_DEFINES_VH
`define PMICM_DEFINES_VH
`define PMICM_ADDR_WR 8'h50
`define PMICM_ADDR_RD 8'h51
`define PMICM_PTR_HOLD 8'h00
`define PMICM_CLK_HZ 10000000
`define PMICM_SCL_HZ 400000
`define PMICM_QTR_CYC ((`PMICM_CLK_HZ + 4 * `PMICM_SCL_HZ - 1) / (4 * `PMICM_SCL_HZ))
`define PMICM_CNT_W 8
`define PMICM_BIT_LAST 4'h8
`define PMICM_OP_WRITE 1'b0
`define PMICM_OP_READ 1'b1
`endif

/* pmicm_tick.v */
/*
 what the file holds: quarter-period tick generator for the serial clock
 assumes: mclk at 10 mhz, synchronous active-low reset
*/
`timescale 1ns/100ps
`include "pmicm_defines.vh"
module pmicm_tick #(
   parameter QTR = `PMICM_QTR_CYC // cycles per quarter bit
) (
   input wire mclk, // system clock
   input wire rst_b, // synchronous reset, active low
   input wire run, // count while high
   output reg tick // one-cycle pulse each quarter
);
   reg [`PMICM_CNT_W-1:0] cnt_reg; // quarter counter
   // free count while running, restart when idle
   always @(posedge mclk) begin
      if (!rst_b || !run) begin
         cnt_reg <= {`PMICM_CNT_W{1'b0}};
         tick <= 1'b0;
      end else if (cnt_reg == QTR[`PMICM_CNT_W-1:0] - 8'h01) begin
         cnt_reg <= {`PMICM_CNT_W{1'b0}};
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
         tick <= 1'b0;
      end
   end
endmodule

/* pmicm_host.v */
/*
 what the file holds: two-wire bus master that writes and reads
 byte registers of the power device through a register pointer
 assumes: open-drain lines with pull-ups, bench resolves the wire;
 user gives one command at a time with start and length
*/
`timescale 1ns/100ps
`include "pmicm_defines.vh"
module pmicm_host #(
   parameter QTR = `PMICM_QTR_CYC // quarter bit in mclk cycles
) (
   input wire mclk, // system clock
   input wire rst_b, // synchronous reset, active low
   input wire cmd_valid, // start a transaction, pulse
   input wire cmd_op, // 0 write, 1 read
   input wire [7:0] cmd_ptr, // register pointer
   input wire [7:0] cmd_len, // byte count, at least one
   input wire [7:0] wr_data, // write byte, held until wr_take
   output reg wr_take, // pulse: wr_data consumed
   output reg [7:0] rd_data, // returned byte
   output reg rd_valid, // pulse: rd_data valid
   output reg busy, // transaction in progress
   output reg done, // pulse: transaction finished
   output reg nack_err, // level: last transaction saw a nack
   input wire scl_i, // serial clock pin level
   output reg scl_o, // serial clock drive value
   output reg scl_oe, // serial clock drive enable
   input wire sda_i, // serial data pin level
   output reg sda_o, // serial data drive value
   output reg sda_oe // serial data drive enable
);
   // states
   // every frame walks start, bits, ack, then stop or repeated start;
   // unused codes fall back to idle
   localparam S_IDLE = 4'h0;
   localparam S_START = 4'h1;
   localparam S_BIT = 4'h2;
   localparam S_ACK = 4'h3;
   localparam S_STOP = 4'h4;
   localparam S_RSTART = 4'h5;
   // byte phases
   localparam P_AW = 3'h0;
   localparam P_PTR = 3'h1;
   localparam P_WD = 3'h2;
   localparam P_AR = 3'h3;
   localparam P_RD = 3'h4;

   reg [3:0] state_reg; // sequencer state
   reg [2:0] phase_reg; // which byte is moving
   reg [1:0] q_reg; // quarter within a bit
   reg [3:0] bit_reg; // bit index, 8 is ack slot
   reg [7:0] sh_reg; // shift register
   reg [7:0] left_reg; // bytes still to move
   reg op_reg; // latched direction
   reg [7:0] ptr_reg; // latched pointer
   reg scl_s1_reg, scl_s2_reg; // serial clock synchroniser
   reg sda_s1_reg, sda_s2_reg; // serial data synchroniser
   reg run_reg; // tick generator enable
   wire tick; // quarter strobe

   // quarter timing; four quarters per bit keeps the rate legal
   pmicm_tick #(.QTR(QTR)) u_tick (
      .mclk(mclk),
      .rst_b(rst_b),
      .run(run_reg),
      .tick(tick)
   );

   // two-flop synchronisers for the pins
   // the lines are wired and may be held by the device at any time,
   // so only the second flop is ever read by the sequencer
   always @(posedge mclk) begin
      if (!rst_b) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
      end else begin
         scl_s1_reg <= scl_i;
         scl_s2_reg <= scl_s1_reg;
         sda_s1_reg <= sda_i;
         sda_s2_reg <= sda_s1_reg;
      end
   end

   // drive helper: low drives, high releases (open drain)
   function drv_oe;
      input lvl; // wanted line level
      begin
         drv_oe = ~lvl;
      end
   endfunction

   // main sequencer
   // each bit takes four quarter ticks, more while q2 waits on a stretched clock; the clock is only ever driven
   // low or released, and data moves only while the clock is low
   // so that the device never sees a false start or stop
   always @(posedge mclk) begin
      if (!rst_b) begin
         state_reg <= S_IDLE;
         phase_reg <= P_AW;
         q_reg <= 2'h0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         left_reg <= 8'h00;
         op_reg <= `PMICM_OP_WRITE;
         ptr_reg <= 8'h00;
         run_reg <= 1'b0;
         wr_take <= 1'b0;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         nack_err <= 1'b0;
         scl_o <= 1'b0;
         scl_oe <= 1'b0;
         sda_o <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         wr_take <= 1'b0;
         rd_valid <= 1'b0;
         done <= 1'b0;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         case (state_reg)
            // idle: both lines released
            S_IDLE: begin
               scl_oe <= 1'b0;
               sda_oe <= 1'b0;
               if (cmd_valid) begin
                  op_reg <= cmd_op;
                  ptr_reg <= cmd_ptr;
                  left_reg <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
                  busy <= 1'b1;
                  nack_err <= 1'b0;
                  run_reg <= 1'b1;
                  q_reg <= 2'h0;
                  state_reg <= S_START;
               end
            end
            // start: data falls while clock high
            S_START: if (tick) begin
               q_reg <= q_reg + 2'h1;
               if (q_reg == 2'h0) begin
                  sda_oe <= 1'b1;
               end else if (q_reg == 2'h1) begin
                  scl_oe <= 1'b1;
                  sh_reg <= `PMICM_ADDR_WR;
                  phase_reg <= P_AW;
                  bit_reg <= 4'h0;
                  q_reg <= 2'h0;
                  state_reg <= S_BIT;
               end
            end
            // repeated start: release data, raise clock, drop data
            // the device may stretch the clock, so q2 waits for it high
            S_RSTART: if (tick) begin
               q_reg <= q_reg + 2'h1;
               if (q_reg == 2'h0) begin
                  sda_oe <= 1'b0;
               end else if (q_reg == 2'h1) begin
                  scl_oe <= 1'b0;
               end else if (q_reg == 2'h2) begin
                  if (scl_s2_reg) begin
                     sda_oe <= 1'b1;
                  end else begin
                     q_reg <= q_reg; // clock held low, wait
                  end
               end else begin
                  scl_oe <= 1'b1;
                  sh_reg <= `PMICM_ADDR_RD;
                  phase_reg <= P_AR;
                  bit_reg <= 4'h0;
                  q_reg <= 2'h0;
                  state_reg <= S_BIT;
               end
            end
            // eight data bits; q0 set data, q1 raise clock, q2 sample, q3 lower
            // on a read the data line is left released for the device
            S_BIT: if (tick) begin
               q_reg <= q_reg + 2'h1;
               if (q_reg == 2'h0) begin
                  sda_oe <= (phase_reg == P_RD) ? 1'b0 : drv_oe(sh_reg[7]);
               end else if (q_reg == 2'h1) begin
                  scl_oe <= 1'b0;
               end else if (q_reg == 2'h2) begin
                  if (!scl_s2_reg) begin
                     q_reg <= q_reg; // stretched clock
                  end else begin
                     sh_reg <= {sh_reg[6:0], sda_s2_reg};
                  end
               end else begin
                  scl_oe <= 1'b1;
                  if (bit_reg == 4'h7) begin
                     bit_reg <= `PMICM_BIT_LAST;
                     state_reg <= S_ACK;
                  end else begin
                     bit_reg <= bit_reg + 4'h1;
                  end
               end
            end
            // ninth pulse: device acks our byte, or we ack its byte and nack the last one
            S_ACK: if (tick) begin
               q_reg <= q_reg + 2'h1;
               if (q_reg == 2'h0) begin
                  if (phase_reg == P_RD) begin
                     rd_data <= sh_reg;
                     rd_valid <= 1'b1;
                     sda_oe <= (left_reg != 8'h01);
                  end else begin
                     sda_oe <= 1'b0; // release for device ack
                  end
               end else if (q_reg == 2'h1) begin
                  scl_oe <= 1'b0;
               end else if (q_reg == 2'h2) begin
                  if (!scl_s2_reg) begin
                     q_reg <= q_reg;
                  end else if (phase_reg != P_RD && sda_s2_reg) begin
                     nack_err <= 1'b1;
                  end
               end else begin
                  // clock falls alone; data moves a quarter later so a
                  // released data line never falls with the clock high
                  scl_oe <= 1'b1;
                  bit_reg <= 4'h0;
                  if (nack_err) begin
                     state_reg <= S_STOP;
                  end else if (phase_reg == P_AW) begin
                     sh_reg <= ptr_reg;
                     phase_reg <= P_PTR;
                     state_reg <= S_BIT;
                  end else if (phase_reg == P_PTR) begin
                     if (op_reg == `PMICM_OP_READ) begin
                        state_reg <= S_RSTART;
                     end else begin
                        sh_reg <= wr_data;
                        wr_take <= 1'b1;
                        phase_reg <= P_WD;
                        state_reg <= S_BIT;
                     end
                  end else if (phase_reg == P_AR) begin
                     phase_reg <= P_RD;
                     state_reg <= S_BIT;
                  end else if (left_reg == 8'h01) begin
                     state_reg <= S_STOP;
                  end else begin
                     left_reg <= left_reg - 8'h01;
                     if (phase_reg == P_WD) begin
                        sh_reg <= wr_data;
                        wr_take <= 1'b1;
                     end
                     state_reg <= S_BIT;
                  end
               end
            end
            // stop: data rises while clock high
            // data is pulled low first, with the clock still low,
            // so the only edge seen with the clock high is the rise
            S_STOP: if (tick) begin
               q_reg <= q_reg + 2'h1;
               if (q_reg == 2'h0) begin
                  sda_oe <= 1'b1;
               end else if (q_reg == 2'h1) begin
                  scl_oe <= 1'b0;
               end else if (q_reg == 2'h2) begin
                  if (scl_s2_reg) begin
                     sda_oe <= 1'b0;
                  end else begin
                     q_reg <= q_reg;
                  end
               end else begin
                  run_reg <= 1'b0;
                  busy <= 1'b0;
                  done <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end
endmodule

/* pmicm_props.sv */
/* checker: line and handshake checks on the host ports
 assumes: bound to pmicm_host, qtr handed down */
`timescale 1ns/100ps
module pmicm_props #(
   parameter QTR = 7 // quarter bit
) (
   input wire mclk, // clock
   input wire rst_b, // reset
   input wire cmd_valid, // request
   input wire cmd_op, // direction
   input wire wr_take, // byte taken
   input wire rd_valid, // byte out
   input wire busy, // active
   input wire done, // end
   input wire nack_err, // refusal
   input wire scl_oe, // clock pull
   input wire sda_oe // data pull
);
   reg [15:0] rel_n; // cycles clock released
   reg op_q; // direction in flight
   // count released clock, latch direction
   always @(posedge mclk) begin
      if (!rst_b || scl_oe)
         rel_n <= 16'h0000;
      else
         rel_n <= rel_n + 16'h0001;
      if (!rst_b)
         op_q <= 1'b0;
      else if (cmd_valid && !busy)
         op_q <= cmd_op;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_idle_release: assert property (!busy && !done |-> !scl_oe && !sda_oe)
      else $error("line pulled while idle");
   a_clk_high_min: assert property ($rose(scl_oe) |-> rel_n >= QTR)
      else $error("clock high too short");
   a_start_clk: assert property ($rose(sda_oe) && !scl_oe && !$past(scl_oe) |-> ##[1:20] scl_oe)
      else $error("start not followed by clock");
   a_stop_done: assert property ($fell(sda_oe) && !scl_oe && !$past(scl_oe) |-> ##[0:40] done)
      else $error("stop without done");
   a_cmd_busy: assert property (cmd_valid && !busy |=> busy)
      else $error("command not taken");
   a_done_end: assert property (done |-> !scl_oe && !sda_oe ##1 !busy && !done)
      else $error("bad end of transfer");
   a_rd_dir: assert property (rd_valid |-> busy && op_q)
      else $error("read byte in write");
   a_wr_dir: assert property (wr_take |-> busy && !op_q)
      else $error("write byte in read");
   a_nack_clr: assert property (cmd_valid && !busy |=> ##[0:1] !nack_err)
      else $error("refusal flag kept");
   c_read: cover property (rd_valid);
   c_write: cover property (wr_take);
   c_nack: cover property ($rose(nack_err));
endmodule
bind pmicm_host pmicm_props #(.QTR(QTR)) u_props (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid),
   .cmd_op(cmd_op), .wr_take(wr_take), .rd_valid(rd_valid), .busy(busy), .done(done),
   .nack_err(nack_err), .scl_oe(scl_oe), .sda_oe(sda_oe));

/* pmicm_dev.sv */
/* device model: register port of the power device on the two-wire bus
 assumes: scl and sda are the resolved open-drain levels */
`timescale 1ns/100ps
module pmicm_dev #(
   parameter NREG = 8'h13 // first invalid pointer
) (
   input wire scl, // wired clock
   input wire sda, // wired data
   input wire slow, // stretch clock
   output reg scl_oe, // pull clock low
   output reg sda_oe // pull data low
);
   reg [7:0] mem [0:255]; // registers
   reg [7:0] ptr; // pointer
   reg [7:0] sh; // shifter
   reg mack; // ack seen in slot
   integer bc = 0; // bit in byte
   integer ph = 4; // 0 addr 1 ptr 2 write 3 read 4 quiet
   initial scl_oe = 1'b0;
   initial sda_oe = 1'b0;
   // start and stop seen with clock high
   always @(negedge sda) if (scl) begin
      ph = 0;
      bc = 0;
   end
   always @(posedge sda) if (scl) ph = 4;
   // sample on rising clock
   always @(posedge scl) begin
      if (bc < 8)
         sh = {sh[6:0], sda};
      else
         mack = !sda;
      bc = bc + 1;
   end
   // drive on falling clock
   always @(negedge scl) begin
      if (bc == 8) begin
         sda_oe = 1'b0;
         if (ph == 0 && sh[7:1] == 7'h28) begin
            sda_oe = 1'b1;
            ph = sh[0] ? 3 : 1;
         end else if (ph == 1 && sh < NREG) begin
            ptr = sh;
            sda_oe = 1'b1;
            ph = 2;
         end else if (ph == 2) begin
            mem[ptr] = sh;
            if (ptr != 8'h00) ptr = ptr + 8'h01;
            sda_oe = 1'b1;
         end else if (ph != 3) ph = 4;
      end else if (bc == 9) begin
         bc = 0;
         sda_oe = 1'b0;
         if (ph == 3 && mack) begin
            sh = mem[ptr];
            if (ptr != 8'h00) ptr = ptr + 8'h01;
            sda_oe = !sh[7];
         end else if (ph == 3) ph = 4;
      end else if (ph == 3) sda_oe = !sh[7];
   end
   // slow answer: hold clock low a while
   always @(negedge scl) if (slow && ph != 4) begin
      scl_oe = 1'b1;
      #1500 scl_oe = 1'b0;
   end
endmodule

/* test_pmic_i2c_register_port.sv */
/* bench: host controller against the device model and a reference memory
 assumes: design and model files compiled first */
`timescale 1ns/100ps
module test_pmic_i2c_register_port;
   reg mclk = 0; // clock
   reg rst_b = 0; // reset
   reg cmd_valid = 0; // request
   reg cmd_op = 0; // direction
   reg [7:0] cmd_ptr = 0; // pointer
   reg [7:0] cmd_len = 0; // count
   reg [7:0] wr_data = 0; // write byte
   reg slow = 0; // device stretches
   wire wr_take, rd_valid, busy, done, nack_err, scl_oe, sda_oe, d_scl_oe, d_sda_oe; // status, drives
   wire [7:0] rd_data; // read byte
   wire scl_o_w, sda_o_w; // drive values, open drain so always low
   wire scl = !(scl_oe || d_scl_oe); // pulled-up clock
   wire sda = !(sda_oe || d_sda_oe); // pulled-up data
   integer mismatches = 0; // failures
   integer samples_checked = 0; // compares
   integer sd; // seed result
   reg [7:0] ref_mem [0:255]; // expected registers
   always #50 mclk = !mclk;
   pmicm_host #(.QTR(2)) dut (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
      .rd_valid(rd_valid), .busy(busy), .done(done), .nack_err(nack_err), .scl_i(scl), .scl_o(scl_o_w),
      .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o_w), .sda_oe(sda_oe));
   pmicm_dev dev (.scl(scl), .sda(sda), .slow(slow), .scl_oe(d_scl_oe), .sda_oe(d_sda_oe));
   // compare one value
   task chk(input string what, input [7:0] exp, input [7:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checked %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // one transfer; a second request while busy must be ignored
   task run(input op, input [7:0] p, input [7:0] n, input bad);
      integer i;
      reg [7:0] q;
      reg [7:0] wd;
      begin
         q = p;
         wd = $urandom;
         cmd_op <= op;
         cmd_ptr <= p;
         cmd_len <= n;
         wr_data <= wd;
         for (i = 0; i < 9000 && done !== 1'b1; i = i + 1) begin
            cmd_valid <= (i == 0 || i == 60);
            @(posedge mclk);
            if (wr_take === 1'b1) begin
               ref_mem[q] = wd;
               if (q != 8'h00) q = q + 8'h01;
               wd = $urandom;
               wr_data <= wd;
            end
            if (rd_valid === 1'b1) begin
               chk("rd_data", ref_mem[q], rd_data);
               if (q != 8'h00) q = q + 8'h01;
            end
         end
         if (i == 9000) begin
            $display("[ERR] done expected 1 seen 0");
            mismatches = mismatches + 1;
            print_verdict;
         end
         chk("nack_err", {7'h00, bad}, {7'h00, nack_err});
         @(posedge mclk);
         chk("busy", 8'h00, {7'h00, busy});
         chk("scl_o", 8'h00, {7'h00, scl_o_w});
         chk("sda_o", 8'h00, {7'h00, sda_o_w});
      end
   endtask
   initial begin
      sd = $urandom(25778);
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      run(1'b0, 8'h05, 8'h01, 1'b0);
      run(1'b1, 8'h05, 8'h01, 1'b0);
      run(1'b0, 8'h12, 8'h01, 1'b0);
      run(1'b1, 8'h12, 8'h01, 1'b0);
      slow <= 1'b1;
      run(1'b0, 8'h07, 8'h03, 1'b0);
      run(1'b1, 8'h07, 8'h03, 1'b0);
      slow <= 1'b0;
      run(1'b0, 8'h00, 8'h02, 1'b0);
      run(1'b1, 8'h00, 8'h02, 1'b0);
      run(1'b0, 8'h13, 8'h01, 1'b1);
      run(1'b1, 8'hff, 8'h02, 1'b1);
      print_verdict;
   end
endmodule
